/* File: mcuid_pkg.sv */
// Purpose: Shared constants for the instruction decode and cycle timing core.
// Assumes: 13-bit instruction words and 8-bit data registers.
// Notes:   Opcode constants are full words; field positions are bit indices.
`default_nettype none

package mcuid_pkg;

   localparam int INSTR_W = 13;
   localparam int DATA_W  = 8;
   localparam int RADDR_W = 6;
   localparam int IOC_W   = 4;
   localparam int K10_W   = 10;

   // Option word field that selects the cycle length.
   localparam int OPT_CYCLE_BIT = 8;

   // Oscillator clocks per instruction cycle, minus one.
   localparam logic [1:0] CYC_LAST_SHORT = 2'h1;
   localparam logic [1:0] CYC_LAST_LONG  = 2'h3;

   // Register operand that addresses the program counter.
   localparam logic [RADDR_W-1:0] PC_REG_ADDR = 6'h02;

   // Reset values.
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

   // Whole-word control and clear opcodes.
   localparam logic [INSTR_W-1:0] OP_NOP      = 13'h0000;
   localparam logic [INSTR_W-1:0] OP_DEC_ADJ    = 13'h0001;
   localparam logic [INSTR_W-1:0] OP_CTRL_WR    = 13'h0002;
   localparam logic [INSTR_W-1:0] OP_SLEEP      = 13'h0003;
   localparam logic [INSTR_W-1:0] OP_WDOG_CLR   = 13'h0004;
   localparam logic [INSTR_W-1:0] OP_IRQ_ON     = 13'h0010;
   localparam logic [INSTR_W-1:0] OP_IRQ_OFF    = 13'h0011;
   localparam logic [INSTR_W-1:0] OP_SUB_RETURN = 13'h0012;
   localparam logic [INSTR_W-1:0] OP_INT_RETURN = 13'h0013;
   localparam logic [INSTR_W-1:0] OP_CTRL_RD    = 13'h0014;
   localparam logic [INSTR_W-1:0] OP_ACC_ZERO = 13'h0080;

   // Register-operand ALU groups, held in word bits 10..7 when bits 12..11 are zero.
   typedef enum logic [3:0] {
      MCUID_G_CTRL = 4'h0, MCUID_G_CLR  = 4'h1, MCUID_G_SUB  = 4'h2, MCUID_G_DEC = 4'h3,
      MCUID_G_OR   = 4'h4, MCUID_G_AND  = 4'h5, MCUID_G_XOR  = 4'h6, MCUID_G_ADD = 4'h7,
      MCUID_G_DSKIP = 4'hB, MCUID_G_ISKIP = 4'hF
   } mcuid_grp_t;

   // Literal group selectors, held in word bits 11..8 when bit 12 is one.
   localparam logic [3:0] LIT_MOV  = 4'h8;
   localparam logic [3:0] LIT_RETURN = 4'hC;

endpackage

`default_nettype wire

/* File: mcuid_core.sv */
// Purpose: Instruction decode, execution and cycle timing of an 8-bit core.
// Assumes: Register and I/O-control read data answer combinationally to the addresses.
// Notes:   Program counter, stack and register file live outside this block.
//
// The strobed register port and the address map were chosen for this implementation.
`default_nettype none

module mcuid_core (
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               nrst,
   // Option strap and wake-up
   input  wire logic [mcuid_pkg::INSTR_W-1:0]      option_word,
   input  wire logic                               wake,
   // Instruction stream
   input  wire logic [mcuid_pkg::INSTR_W-1:0]      instr_word,
   output logic                                    instr_take,
   // Register file
   output logic [mcuid_pkg::RADDR_W-1:0]           reg_addr,
   input  wire logic [mcuid_pkg::DATA_W-1:0]       reg_rdata,
   output logic                                    reg_we,
   output logic [mcuid_pkg::RADDR_W-1:0]           reg_waddr,
   output logic [mcuid_pkg::DATA_W-1:0]            reg_wdata,
   // I/O control registers
   output logic [mcuid_pkg::IOC_W-1:0]             ioc_addr,
   input  wire logic [mcuid_pkg::DATA_W-1:0]       ioc_rdata,
   output logic                                    ioc_we,
   output logic [mcuid_pkg::IOC_W-1:0]             ioc_waddr,
   output logic [mcuid_pkg::DATA_W-1:0]            ioc_wdata,
   // Program flow
   output logic                                    jump_take,
   output logic [mcuid_pkg::K10_W-1:0]             jump_addr,
   output logic                                    stack_push,
   output logic                                    stack_pop,
   // Core state
   output logic [mcuid_pkg::DATA_W-1:0]            acc,
   output logic [mcuid_pkg::DATA_W-1:0]            core_control_reg,
   output logic                                    flag_z,
   output logic                                    flag_c,
   output logic                                    flag_dc,
   output logic                                    flag_t,
   output logic                                    flag_p,
   output logic                                    irq_enable,
   output logic                                    watchdog_clear,
   output logic                                    osc_stop,
   output logic                                    timer_counter_input,
   output logic                                    cycle_length_option,
   output logic                                    extra_cycle
);
   import mcuid_pkg::*;

   logic                opt_loaded;
   logic [1:0]          osc_cnt;
   logic [1:0]          cyc_last;
   logic                run;
   logic                exec;
   logic [INSTR_W-1:0]  w;
   logic [DATA_W-1:0]   k8;
   logic [2:0]          bpos;
   logic                dir;
   mcuid_grp_t          grp;

   logic [DATA_W-1:0]   next_acc;
   logic [DATA_W-1:0]   next_ctrl;
   logic                next_z;
   logic                next_c;
   logic                next_dc;
   logic                next_t;
   logic                next_p;
   logic                next_ie;
   logic                next_reg_we;
   logic [DATA_W-1:0]   next_reg_wdata;
   logic                next_ioc_we;
   logic                next_jump;
   logic                next_push;
   logic                next_pop;
   logic                next_wdc;
   logic                next_stop;
   logic                next_two;

   // The strap is caught after reset release, so no port feeds an async load.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         opt_loaded          <= 1'b0;
         cycle_length_option <= 1'b0;
      end else if (!opt_loaded) begin
         opt_loaded          <= 1'b1;
         cycle_length_option <= option_word[OPT_CYCLE_BIT];
      end
   end

   assign cyc_last = cycle_length_option ? CYC_LAST_LONG : CYC_LAST_SHORT;
   assign run      = opt_loaded && !osc_stop;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_cnt <= 2'h0;
      end else if (run) begin
         osc_cnt <= (osc_cnt == cyc_last) ? 2'h0 : osc_cnt + 2'h1;
      end
   end

   // One take per instruction cycle; the timer sees the same rate.
   assign instr_take          = run && (osc_cnt == cyc_last);
   assign timer_counter_input = instr_take;
   assign exec                = instr_take && !extra_cycle;

   // Operand fields.
   assign w        = instr_word;
   assign reg_addr = w[RADDR_W-1:0];
   assign ioc_addr = w[IOC_W-1:0];
   assign k8       = w[DATA_W-1:0];
   assign bpos     = w[8:6];
   assign dir      = w[6];
   assign grp      = mcuid_grp_t'(w[10:7]);

   always_comb begin
      logic [8:0]        sum;
      logic [DATA_W-1:0] res;
      logic              to_reg;
      sum            = 9'h000;
      res            = 8'h00;
      to_reg         = 1'b0;
      next_acc       = acc;
      next_ctrl      = core_control_reg;
      next_z         = flag_z;
      next_c         = flag_c;
      next_dc        = flag_dc;
      next_t         = flag_t;
      next_p         = flag_p;
      next_ie        = irq_enable;
      next_reg_we    = 1'b0;
      next_reg_wdata = 8'h00;
      next_ioc_we    = 1'b0;
      next_jump      = 1'b0;
      next_push      = 1'b0;
      next_pop       = 1'b0;
      next_wdc       = 1'b0;
      next_stop      = 1'b0;
      next_two       = 1'b0;
      if (!w[12] && !w[11]) begin
         case (grp)
            MCUID_G_CTRL: begin
               if (dir) begin
                  to_reg      = 1'b1;
                  res         = acc;
               end else begin
                  case (w)
                     OP_NOP: begin
                     end
                     OP_DEC_ADJ: begin
                        sum = {1'b0, acc};
                        if (flag_dc || (acc[3:0] > 4'h9)) begin
                           sum = sum + 9'h006;
                        end
                        if (flag_c || (sum[7:4] > 4'h9) || sum[8]) begin
                           sum = sum + 9'h060;
                        end
                        next_acc = sum[7:0];
                        next_c   = sum[8] || flag_c;
                     end
                     OP_CTRL_WR: next_ctrl = acc;
                     OP_SLEEP: begin
                        next_wdc  = 1'b1;
                        next_stop = 1'b1;
                        next_t    = 1'b1;
                        next_p    = 1'b0;
                     end
                     OP_WDOG_CLR: begin
                        next_wdc = 1'b1;
                        next_t   = 1'b1;
                        next_p   = 1'b1;
                     end
                     OP_IRQ_ON:  next_ie = 1'b1;
                     OP_IRQ_OFF: next_ie = 1'b0;
                     OP_SUB_RETURN, OP_INT_RETURN: begin
                        next_pop = 1'b1;
                        next_two = 1'b1;
                        if (w == OP_INT_RETURN) begin
                           next_ie = 1'b1;
                        end
                     end
                     OP_CTRL_RD: next_acc = core_control_reg;
                     default: begin
                        if (w[5:4] == 2'b00) begin
                           next_ioc_we = 1'b1;
                        end else if (w[5:4] == 2'b01) begin
                           next_acc = ioc_rdata;
                        end
                     end
                  endcase
               end
            end
            MCUID_G_CLR: begin
               if (dir || (w == OP_ACC_ZERO)) begin
                  to_reg = dir;
                  res    = 8'h00;
                  next_z = 1'b1;
                  if (!dir) begin
                     next_acc = 8'h00;
                  end
               end
            end
            MCUID_G_SUB, MCUID_G_ADD: begin
               if (grp == MCUID_G_SUB) begin
                  sum     = {1'b0, reg_rdata} - {1'b0, acc};
                  next_c  = !sum[8];
                  next_dc = reg_rdata[3:0] >= acc[3:0];
               end else begin
                  sum     = {1'b0, reg_rdata} + {1'b0, acc};
                  next_c  = sum[8];
                  next_dc = ({1'b0, reg_rdata[3:0]} + {1'b0, acc[3:0]}) > 5'h0F;
               end
               res    = sum[7:0];
               to_reg = dir;
               next_z = (res == 8'h00);
            end
            MCUID_G_DEC, MCUID_G_DSKIP, MCUID_G_ISKIP: begin
               res    = (grp == MCUID_G_ISKIP) ? reg_rdata + 8'h01 : reg_rdata - 8'h01;
               to_reg = dir;
               if (grp == MCUID_G_DEC) begin
                  next_z = (res == 8'h00);
               end else if (res == 8'h00) begin
                  next_two = 1'b1;
               end
            end
            MCUID_G_OR, MCUID_G_AND, MCUID_G_XOR: begin
               if (grp == MCUID_G_OR) begin
                  res = acc | reg_rdata;
               end else if (grp == MCUID_G_AND) begin
                  res = acc & reg_rdata;
               end else begin
                  res = acc ^ reg_rdata;
               end
               to_reg = dir;
               next_z = (res == 8'h00);
            end
            default: begin
            end
         endcase
         // Groups other than control and clear write the accumulator when the direction bit is low.
         if ((grp != MCUID_G_CTRL) && (grp != MCUID_G_CLR) && !dir) begin
            if ((grp <= MCUID_G_ADD) || (grp == MCUID_G_DSKIP) || (grp == MCUID_G_ISKIP)) begin
               next_acc = res;
            end
         end
      end else if (!w[12]) begin
         // Bit clear, set and the two bit tests.
         res = reg_rdata;
         case (w[10:9])
            2'b00: begin
               res[bpos] = 1'b0;
               to_reg    = 1'b1;
            end
            2'b01: begin
               res[bpos] = 1'b1;
               to_reg    = 1'b1;
            end
            2'b10: next_two = !reg_rdata[bpos];
            default: next_two = reg_rdata[bpos];
         endcase
      end else if (!w[11]) begin
         next_jump = 1'b1;
         next_push = !w[10];
         next_two  = 1'b1;
      end else begin
         case (w[11:8])
            LIT_MOV:  next_acc = k8;
            LIT_RETURN: begin
               next_acc = k8;
               next_pop = 1'b1;
               next_two = 1'b1;
            end
            default: begin
            end
         endcase
      end
      if (to_reg) begin
         next_reg_we    = 1'b1;
         next_reg_wdata = res;
         if (reg_addr == PC_REG_ADDR) begin
            next_two = 1'b1;
         end
      end
   end

   // Architectural state changes only when a live instruction executes.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc              <= ACC_RST;
         core_control_reg <= CTRL_RST;
         flag_z           <= 1'b0;
         flag_c           <= 1'b0;
         flag_dc          <= 1'b0;
         flag_t           <= 1'b1;
         flag_p           <= 1'b1;
         irq_enable       <= 1'b0;
      end else if (exec) begin
         acc              <= next_acc;
         core_control_reg <= next_ctrl;
         flag_z           <= next_z;
         flag_c           <= next_c;
         flag_dc          <= next_dc;
         flag_t           <= next_t;
         flag_p           <= next_p;
         irq_enable       <= next_ie;
      end
   end

   // Side-effect strobes last one clock, in the take cycle's next clock.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_we         <= 1'b0;
         reg_waddr      <= 6'h00;
         reg_wdata      <= 8'h00;
         ioc_we         <= 1'b0;
         ioc_waddr      <= 4'h0;
         ioc_wdata      <= 8'h00;
         jump_take      <= 1'b0;
         jump_addr      <= 10'h000;
         stack_push     <= 1'b0;
         stack_pop      <= 1'b0;
         watchdog_clear <= 1'b0;
      end else begin
         reg_we         <= exec && next_reg_we;
         ioc_we         <= exec && next_ioc_we;
         jump_take      <= exec && next_jump;
         stack_push     <= exec && next_push;
         stack_pop      <= exec && next_pop;
         watchdog_clear <= exec && next_wdc;
         if (exec) begin
            reg_waddr <= reg_addr;
            reg_wdata <= next_reg_wdata;
            ioc_waddr <= ioc_addr;
            ioc_wdata <= acc;
            jump_addr <= w[K10_W-1:0];
         end
      end
   end

   // A stopped oscillator is modelled as a halted sequencer until wake.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_stop <= 1'b0;
      end else if (exec && next_stop) begin
         osc_stop <= 1'b1;
      end else if (wake) begin
         osc_stop <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         extra_cycle <= 1'b0;
      end else if (instr_take) begin
         extra_cycle <= exec && next_two;
      end
   end

   property p_cyc_short;
      @(posedge clk) disable iff (!nrst)
      instr_take && !cycle_length_option |=> !instr_take ##1 (instr_take || osc_stop);
   endproperty
   a_cyc_short: assert property (p_cyc_short) else $error("short cycle is not two clocks");

   property p_cyc_long;
      @(posedge clk) disable iff (!nrst)
      instr_take && cycle_length_option |=> (!instr_take)[*3] ##1 (instr_take || osc_stop);
   endproperty
   a_cyc_long: assert property (p_cyc_long) else $error("long cycle is not four clocks");

   property p_pc_write;
      @(posedge clk) disable iff (!nrst)
      reg_we && (reg_waddr == PC_REG_ADDR) |-> extra_cycle;
   endproperty
   a_pc_write: assert property (p_pc_write) else $error("pc write without extra cycle");

   property p_jump;
      @(posedge clk) disable iff (!nrst)
      (jump_take || stack_pop) |-> extra_cycle;
   endproperty
   a_jump: assert property (p_jump) else $error("flow change without extra cycle");

   property p_flush;
      @(posedge clk) disable iff (!nrst)
      instr_take && extra_cycle |=> $stable(acc) && !reg_we && !jump_take && !extra_cycle;
   endproperty
   a_flush: assert property (p_flush) else $error("discarded word had an effect");

   property p_sleep;
      @(posedge clk) disable iff (!nrst)
      exec && (w == OP_SLEEP) |=> osc_stop && watchdog_clear && flag_t && !flag_p;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep effects missing");

   property p_eni;
      @(posedge clk) disable iff (!nrst)
      exec && (w == OP_IRQ_ON) |=> irq_enable && $stable(flag_z) && $stable(flag_c);
   endproperty
   a_eni: assert property (p_eni) else $error("enable interrupt misbehaved");

   property p_mov;
      @(posedge clk) disable iff (!nrst)
      exec && (w[12:6] == 7'h01) |=> reg_we && (reg_wdata == $past(acc)) && $stable(flag_z) && $stable(flag_c);
   endproperty
   a_mov: assert property (p_mov) else $error("accumulator move wrong");

   property p_acc_zero_op;
      @(posedge clk) disable iff (!nrst)
      exec && (w == OP_ACC_ZERO) |=> (acc == 8'h00) && flag_z;
   endproperty
   a_acc_zero_op: assert property (p_acc_zero_op) else $error("clear accumulator wrong");

   c_skip: cover property (@(posedge clk) disable iff (!nrst) exec && !w[12] && w[11] && w[10] && next_two);
   c_call: cover property (@(posedge clk) disable iff (!nrst) stack_push);
   c_long: cover property (@(posedge clk) disable iff (!nrst) instr_take && cycle_length_option);
   c_wake: cover property (@(posedge clk) disable iff (!nrst) osc_stop ##1 !osc_stop);

endmodule

`default_nettype wire

/* File: mcuid_core_test.sv */
// Purpose: Self-checking bench for the instruction decode and cycle timing core.
// Assumes: The bench stands in for the register file and the I/O control registers.
// Notes:   A reference model of accumulator and flags is compared after each ALU, literal and accumulator instruction.
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module mcu_instruction_decode_timing_test;
   timeunit 1ns;
   timeprecision 1ns;
   import mcuid_pkg::*;
   logic        clk, nrst, wake, instr_take, reg_we, ioc_we, jump_take, stack_push, stack_pop;
   logic        flag_z, flag_c, flag_dc, flag_t, flag_p, irq_enable, watchdog_clear, osc_stop;
   logic        timer_counter_input, cycle_length_option, extra_cycle;
   logic [12:0] option_word, instr_word, w;
   logic [7:0]  reg_rdata, ioc_rdata, reg_wdata, ioc_wdata, acc, core_control_reg, m_acc, k, rv;
   logic [5:0]  reg_addr, reg_waddr, r;
   logic [3:0]  ioc_addr, ioc_waddr, g;
   logic [9:0]  jump_addr;
   logic        m_z, m_c, m_dc, d;
   int          n_errors, checked, res, a;

   mcuid_core DUT (.clk(clk), .nrst(nrst), .option_word(option_word), .wake(wake), .instr_word(instr_word),
      .instr_take(instr_take), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_we(reg_we),
      .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .ioc_addr(ioc_addr), .ioc_rdata(ioc_rdata),
      .ioc_we(ioc_we), .ioc_waddr(ioc_waddr), .ioc_wdata(ioc_wdata), .jump_take(jump_take),
      .jump_addr(jump_addr), .stack_push(stack_push), .stack_pop(stack_pop), .acc(acc),
      .core_control_reg(core_control_reg), .flag_z(flag_z), .flag_c(flag_c), .flag_dc(flag_dc),
      .flag_t(flag_t), .flag_p(flag_p), .irq_enable(irq_enable), .watchdog_clear(watchdog_clear),
      .osc_stop(osc_stop), .timer_counter_input(timer_counter_input),
      .cycle_length_option(cycle_length_option), .extra_cycle(extra_cycle));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #3000000;
      n_errors++;
      results();
   end

   task automatic do_reset(input logic lng);
      nrst <= 1'b0;
      option_word <= {4'h0, lng, 8'h00};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      {m_acc, m_z, m_c, m_dc} = 11'h000;
   endtask

   // Drives a word just after an edge, waits for its take edge, then samples a half clock later.
   task automatic exec(input logic [12:0] wd, input logic [7:0] rd);
      int n;
      @(posedge clk);
      instr_word <= wd;
      reg_rdata <= rd;
      ioc_rdata <= rd;
      n = 0;
      @(negedge clk);
      while (instr_take !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
   endtask

   task automatic chk_st();
      `CHK("acc", m_acc, acc)
      `CHK("z", m_z, flag_z)
      `CHK("c", m_c, flag_c)
      `CHK("dc", m_dc, flag_dc)
   endtask

   // The word after a two-cycle instruction must change nothing.
   task automatic discard();
      exec(13'h0388, 8'h5A);
      chk_st();
      `CHK("xc_end", 1'b0, extra_cycle)
   endtask

   task automatic spacing(input int exp);
      int n;
      n = 0;
      do @(negedge clk); while (instr_take !== 1'b1);
      `CHK("tmr", instr_take, timer_counter_input)
      do begin
         @(negedge clk);
         n++;
      end while (instr_take !== 1'b1 && n < 20);
      `CHK("period", exp, n)
   endtask

   task automatic two_cyc(input logic [12:0] wd, input logic pop);
      exec(wd, 8'h00);
      `CHK("pop", pop, stack_pop)
      `CHK("xc", 1'b1, extra_cycle)
      discard();
   endtask

   initial begin
      {nrst, wake, option_word, instr_word, reg_rdata, ioc_rdata} = '0;
      void'($urandom(32'hB8CAB898));
      do_reset(1'b0);
      `CHK("t_rst", 1'b1, flag_t)
      spacing(2);
      for (int i = 0; i < 60; i++) begin
         if (i % 4 == 0) begin
            k = $urandom;
            exec({5'h18, k}, 8'h00);
            m_acc = k;
            chk_st();
         end
         g = 4'(1 + $urandom % 7);
         d = $urandom;
         r = 6'(3 + $urandom % 61);
         rv = $urandom;
         w = (g == 4'h1 && !d) ? OP_ACC_ZERO : {2'b00, g, d, r};
         a = m_acc;
         case (g)
            4'h1: res = 0;
            4'h2: begin res = rv - a; m_c = rv >= a; m_dc = rv % 16 >= a % 16; end
            4'h3: res = rv - 1;
            4'h4: res = a | rv;
            4'h5: res = a & rv;
            4'h6: res = a ^ rv;
            default: begin res = a + rv; m_c = res > 255; m_dc = a % 16 + rv % 16 > 15; end
         endcase
         res = res & 255;
         m_z = res == 0;
         exec(w, rv);
         `CHK("we", d, reg_we)
         if (d) `CHK("wd", {r, res[7:0]}, {reg_waddr, reg_wdata})
         else m_acc = res[7:0];
         chk_st();
      end
      exec(OP_IRQ_ON, 8'h00);
      `CHK("ie", 1'b1, irq_enable)
      exec(OP_IRQ_OFF, 8'h00);
      `CHK("ie", 1'b0, irq_enable)
      two_cyc(OP_INT_RETURN, 1'b1);
      `CHK("ie", 1'b1, irq_enable)
      two_cyc(OP_SUB_RETURN, 1'b1);
      m_acc = k;
      two_cyc({5'h1C, k}, 1'b1);
      chk_st();
      exec({3'b100, 10'h2A5}, 8'h00);
      `CHK("call", 12'hEA5, {stack_push, jump_take, jump_addr})
      discard();
      two_cyc({3'b101, 10'h15A}, 1'b0);
      exec(13'h0042, 8'h00);
      `CHK("pcw", {1'b1, 6'h02, m_acc, 1'b1}, {reg_we, reg_waddr, reg_wdata, extra_cycle})
      discard();
      exec(OP_CTRL_WR, 8'h00);
      `CHK("ctl", m_acc, core_control_reg)
      k = m_acc;
      exec(OP_ACC_ZERO, 8'h00);
      {m_acc, m_z} = 9'h001;
      chk_st();
      exec(OP_CTRL_RD, 8'h00);
      m_acc = k;
      chk_st();
      rv = $urandom;
      r = 6'(5 + $urandom % 11);
      exec({9'h000, r[3:0]}, 8'h00);
      `CHK("iow", {1'b1, r[3:0], m_acc}, {ioc_we, ioc_waddr, ioc_wdata})
      exec({9'h001, r[3:0]}, rv);
      m_acc = rv;
      chk_st();
      for (int b = 0; b < 8; b++) begin
         exec({4'b0101, 3'(b), 6'h09}, rv);
         `CHK("bs", rv | 8'(1 << b), reg_wdata)
         exec({4'b0100, 3'(b), 6'h09}, rv);
         `CHK("bc", rv & ~8'(1 << b), reg_wdata)
         exec({4'b0111, 3'(b), 6'h09}, rv);
         `CHK("jbs", rv[b], extra_cycle)
         if (rv[b]) discard();
      end
      exec(OP_SLEEP, 8'h00);
      `CHK("slp", 4'hB, {flag_t, flag_p, watchdog_clear, osc_stop})
      repeat (8) begin
         @(negedge clk);
         `CHK("halt", 1'b0, instr_take)
      end
      // The first take after wake must not see the sleep word again.
      @(posedge clk);
      instr_word <= OP_NOP;
      wake <= 1'b1;
      repeat (2) @(posedge clk);
      wake <= 1'b0;
      exec(OP_WDOG_CLR, 8'h00);
      `CHK("wdc", 4'hE, {flag_t, flag_p, watchdog_clear, osc_stop})
      chk_st();
      do_reset(1'b1);
      spacing(4);
      `CHK("opt", 1'b1, cycle_length_option)
      exec({3'b101, 10'h0C3}, 8'h00);
      `CHK("jmp", 11'h4C3, {jump_take, jump_addr})
      discard();
      results();
   end
endmodule
`undef CHK
`default_nettype wire
